// file: design/pdd_pkg.sv
package pdd_pkg;

    //////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned NUM_PAIRS = 3;
    localparam int unsigned DUTY_W    = 16;
    localparam int unsigned CNT_W     = 15;
    localparam int unsigned DT_W      = 6;
    localparam int unsigned DT_PS_W   = 2;
    localparam int unsigned DT_PRE_W  = 3;
    localparam int unsigned ADDR_W    = 8;

    //////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_TBCON     = 8'h00;
    localparam logic [7:0] ADDR_TBCOUNT   = 8'h04;
    localparam logic [7:0] ADDR_PERIOD    = 8'h08;
    localparam logic [7:0] ADDR_CON1      = 8'h0C;
    localparam logic [7:0] ADDR_CON2      = 8'h10;
    localparam logic [7:0] ADDR_DTC1      = 8'h14;
    localparam logic [7:0] ADDR_DTC2      = 8'h18;
    localparam logic [7:0] ADDR_OVD       = 8'h1C;
    localparam logic [7:0] ADDR_DUTY_BASE = 8'h20;
    localparam logic [7:0] ADDR_DUTY_STEP = 8'h04;

    //////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned TBCON_EN_BIT   = 15;
    localparam int unsigned TBCON_MODE_LSB = 0;
    localparam int unsigned CON2_UPDATE_DISABLE_BIT  = 0;
    localparam int unsigned CON2_IUE_BIT   = 1;
    localparam int unsigned DTC1_FIRST_LSB = 0;
    localparam int unsigned DTC1_FPS_LSB   = 6;
    localparam int unsigned DTC1_SECND_LSB = 8;
    localparam int unsigned DTC1_SPS_LSB   = 14;
    localparam int unsigned OVD_EN_LSB     = 8;

    //////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] TBCON_RST = 16'h0000;
    localparam logic [14:0] PERIOD_RST = 15'h0000;
    localparam logic [15:0] CON1_RST  = 16'h0000;
    localparam logic [15:0] CON2_RST  = 16'h0000;
    localparam logic [15:0] DTC_RST   = 16'h0000;
    localparam logic [15:0] OVD_RST   = 16'h0000;
    localparam logic [15:0] DUTY_RST  = 16'h0000;

    //////////////////////////////////////////////////////////////////////
    // Time base modes
    localparam logic [1:0] MODE_FREE   = 2'b00;
    localparam logic [1:0] MODE_UPDOWN = 2'b01;
    localparam logic [1:0] MODE_SINGLE = 2'b10;
    localparam logic [1:0] MODE_DOUBLE = 2'b11;

    // Time base state offered by the outside counter
    typedef struct packed {
        logic [14:0] count;
        logic        dir;
        logic        half;
        logic        period_match;
    } pdd_tb_s;

endpackage : pdd_pkg

// file: design/pdd_duty.sv
`timescale 1ns/1ps
module pdd_duty (
    input  logic                       pclk,
    input  logic                       presetn,
    input  logic                       ce,
    input  logic                       wr,
    input  logic [pdd_pkg::DUTY_W-1:0] wdata,
    input  logic                       load,
    input  logic                       immediate,
    input  logic [pdd_pkg::CNT_W-1:0]  tb_count,
    input  logic                       tb_half,
    output logic [pdd_pkg::DUTY_W-1:0] buffer,
    output logic [pdd_pkg::DUTY_W-1:0] active,
    output logic                       cmp
);
    import pdd_pkg::*;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer <= DUTY_RST;
            active <= DUTY_RST;
        end else if (ce) begin
            if (wr) begin
                buffer <= wdata; // RULE1
            end
            if (wr && immediate) begin
                active <= wdata; // RULE7
            end else if (load) begin
                active <= buffer; // RULE1
            end
        end
    end

    // Half-count bit below the count gives the extra resolution
    assign cmp = {tb_count, tb_half} < active; // RULE2 RULE8

endmodule : pdd_duty

// file: design/pdd_dtu.sv
`timescale 1ns/1ps
module pdd_dtu (
    input  logic                        pclk,
    input  logic                        presetn,
    input  logic                        ce,
    input  logic                        cmp,
    input  logic                        independent,
    input  logic                        sel_active,
    input  logic                        sel_inactive,
    input  logic [pdd_pkg::DT_W-1:0]    dt_first,
    input  logic [pdd_pkg::DT_W-1:0]    dt_second,
    input  logic [pdd_pkg::DT_PS_W-1:0] ps_first,
    input  logic [pdd_pkg::DT_PS_W-1:0] ps_second,
    input  logic                        clear,
    output logic                        high,
    output logic                        low
);
    import pdd_pkg::*;

    logic                cmp_q;
    logic [DT_W-1:0]     cnt;
    logic [DT_PRE_W-1:0] pre;
    logic [DT_PS_W-1:0]  ps_q;

    wire                rise       = cmp & ~cmp_q; // RULE12
    wire                fall       = ~cmp & cmp_q; // RULE12
    wire                use_second = rise ? sel_active : sel_inactive; // RULE13 RULE26
    wire [DT_W-1:0]     load_val   = use_second ? dt_second : dt_first;
    wire [DT_PS_W-1:0]  load_ps    = use_second ? ps_second : ps_first;
    wire [DT_PRE_W-1:0] pre_max    = DT_PRE_W'((4'd1 << ps_q) - 4'd1); // RULE14
    wire                tick       = pre == pre_max;
    wire                dead       = cnt != '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= 1'b0;
            cnt   <= '0;
            pre   <= '0;
            ps_q  <= '0;
        end else if (ce) begin
            cmp_q <= cmp;
            if ((rise || fall) && !independent) begin
                cnt  <= load_val; // RULE15
                ps_q <= load_ps;
                pre  <= '0; // RULE16
            end else if (clear) begin
                pre <= '0; // RULE16
            end else if (dead) begin
                if (tick) begin
                    cnt <= cnt - 1'b1; // RULE12
                    pre <= '0;
                end else begin
                    pre <= pre + 1'b1;
                end
            end
        end
    end

    // Turn-off is immediate, turn-on waits out the counter
    assign high = independent ? cmp : (cmp & ~rise & ~dead); // RULE11 RULE18
    assign low  = independent ? cmp : (~cmp & ~fall & ~dead); // RULE11 RULE25 RULE19

endmodule : pdd_dtu

// file: design/pdd_top.sv
// Summary of operation
// RULE1 - Three 16-bit duty values, each a writable buffer plus an active copy.
// RULE2 - Duty LSB puts the edge at start or middle of a count.
// RULE3 - Edge-aligned modes load active duty on period match and timer reset.
// RULE4 - Time base off loads duty continuously; edge modes need update disable clear.
// RULE5 - Up/down mode loads duty when timer hits zero counting up.
// RULE6 - Double update mode loads duty at zero and at period match.
// RULE7 - Immediate update writes duty straight into the active copy.
// RULE8 - With immediate update the output follows the new value mid-period.
// RULE9 - Comparator n drives pair n, each pair a high and low pin.
// RULE10 - Pair-mode bit 0 complementary, 1 independent; reset gives complementary.
// RULE11 - Complementary pairs keep both pins off for dead time on each transition.
// RULE12 - Per pair a 6-bit down counter started by compare edges.
// RULE13 - Per pair one bit picks active-edge and one inactive-edge dead time.
// RULE14 - Each dead time has a 2-bit prescale of 1, 2, 4 or 8 cycles.
// RULE15 - Two 6-bit dead-time counts, each times its prescaled tick.
// RULE16 - Prescaler cleared on counter load, dead-time register write and reset.
// RULE17 - Software should not change dead-time registers while time base runs.
// RULE18 - Independent pairs get no dead time and may both be active.
// RULE19 - Independent pins follow the comparator or are forced off or on.
// RULE20 - Mode 10 gives a single pulse: on at enable, off at duty match.
// RULE21 - Single pulse period match clears timer, outputs, enable; raises event. The code clears only high pins and independent-pair low pins.
// RULE22 - Override register: upper byte enables, lower byte forced pin states.
// RULE23 - Update disable blocks buffer transfers except immediate duty writes. While the time base is off the code copies the period regardless.
// RULE24 - Read-only count direction flag: 0 counting up, 1 counting down.
// RULE25 - Complementary low pin is the inverse of the high compare result.
// RULE26 - Dead-time select 0 picks the first value, 1 the second.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module pdd_top #(
    parameter int unsigned NPAIR = pdd_pkg::NUM_PAIRS
) (
    input  logic                        pclk,
    input  logic                        presetn,
    input  logic                        ce,
    input  logic                        psel,
    input  logic                        penable,
    input  logic                        pwrite,
    input  logic [pdd_pkg::ADDR_W-1:0]  paddr,
    input  logic [31:0]                 pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  pdd_pkg::pdd_tb_s            tb_in,
    output logic                        time_base_enable,
    output logic [1:0]                  time_base_mode_field,
    output logic [pdd_pkg::CNT_W-1:0]   period_value,
    output logic                        timer_clear,
    output logic                        single_pulse_done,
    output logic [NPAIR-1:0]            high_side_output,
    output logic [NPAIR-1:0]            low_side_output
);
    import pdd_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // Register state
    logic [CNT_W-1:0]  period_buffer;
    logic [NPAIR-1:0]  pair_mode_select;
    logic              update_disable;
    logic              immediate_update_enable;
    logic [15:0]       dead_time_control_one;
    logic [15:0]       dead_time_control_two;
    logic [15:0]       output_override_control;
    logic              zero_q;

    logic [DUTY_W-1:0] duty_buffer [NPAIR];
    logic [DUTY_W-1:0] duty_active [NPAIR];
    logic [NPAIR-1:0]  cmp_raw;
    logic [NPAIR-1:0]  dt_high;
    logic [NPAIR-1:0]  dt_low;

    //////////////////////////////////////////////////////////////////////
    // APB decode
    wire        setup   = psel & ~penable;
    wire        wr_en   = psel & penable & pwrite & pready;
    wire [15:0] wd      = pwdata[15:0];

    wire sel_tbcon   = paddr == ADDR_TBCON;
    wire sel_tbcount = paddr == ADDR_TBCOUNT;
    wire sel_period  = paddr == ADDR_PERIOD;
    wire sel_con1    = paddr == ADDR_CON1;
    wire sel_con2    = paddr == ADDR_CON2;
    wire sel_dtc1    = paddr == ADDR_DTC1;
    wire sel_dtc2    = paddr == ADDR_DTC2;
    wire sel_ovd     = paddr == ADDR_OVD;

    logic [NPAIR-1:0] sel_duty;
    logic [15:0]      duty_rd [NPAIR+1];

    genvar gi;
    generate
        for (gi = 0; gi < NPAIR; gi++) begin : g_dsel
            assign sel_duty[gi] = paddr == ADDR_W'(ADDR_DUTY_BASE + gi * ADDR_DUTY_STEP);
        end
    endgenerate

    wire mapped = sel_tbcon | sel_tbcount | sel_period | sel_con1 | sel_con2
                | sel_dtc1 | sel_dtc2 | sel_ovd | (|sel_duty);

    //////////////////////////////////////////////////////////////////////
    // Read data selection
    wire [15:0] tbcon_rd  = {time_base_enable, 13'h0000, time_base_mode_field};
    wire [15:0] count_rd  = {tb_in.dir, tb_in.count}; // RULE24
    wire [15:0] con1_rd   = 16'(pair_mode_select);
    wire [15:0] con2_rd   = {14'h0000, immediate_update_enable, update_disable};

    assign duty_rd[0] = 16'h0000;
    generate
        for (gi = 0; gi < NPAIR; gi++) begin : g_drd
            assign duty_rd[gi+1] = duty_rd[gi] | ({16{sel_duty[gi]}} & duty_buffer[gi]);
        end
    endgenerate

    wire [15:0] rd_mux = ({16{sel_tbcon}}   & tbcon_rd)
                       | ({16{sel_tbcount}} & count_rd)
                       | ({16{sel_period}}  & {1'b0, period_buffer})
                       | ({16{sel_con1}}    & con1_rd)
                       | ({16{sel_con2}}    & con2_rd)
                       | ({16{sel_dtc1}}    & dead_time_control_one)
                       | ({16{sel_dtc2}}    & dead_time_control_two)
                       | ({16{sel_ovd}}     & output_override_control)
                       | duty_rd[NPAIR];

    // Zero wait states: answer registered from the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Update events
    wire sp_mode   = time_base_mode_field == MODE_SINGLE;
    wire edge_mode = (time_base_mode_field == MODE_FREE) | sp_mode;
    wire count_zero = tb_in.count == '0;
    // Entry into zero only, so a stalled count does not reload every cycle
    wire zero_hit  = count_zero & ~zero_q & ~tb_in.dir;

    wire run_evt   = edge_mode ? tb_in.period_match // RULE3
                   : (time_base_mode_field == MODE_UPDOWN) ? zero_hit // RULE5
                   : (zero_hit | tb_in.period_match); // RULE6

    wire duty_load = time_base_enable ? (run_evt & ~update_disable) // RULE23
                   : (edge_mode ? ~update_disable : 1'b1); // RULE4

    wire per_evt   = edge_mode ? tb_in.period_match : zero_hit;
    wire per_load  = time_base_enable ? (per_evt & ~update_disable) : 1'b1; // RULE23

    wire sp_end    = time_base_enable & sp_mode & tb_in.period_match;
    wire dt_clear  = wr_en & (sel_dtc1 | sel_dtc2);

    //////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_base_enable        <= TBCON_RST[TBCON_EN_BIT];
            time_base_mode_field    <= TBCON_RST[TBCON_MODE_LSB +: 2];
            period_buffer           <= PERIOD_RST;
            pair_mode_select        <= NPAIR'(CON1_RST); // RULE10
            update_disable          <= CON2_RST[CON2_UPDATE_DISABLE_BIT];
            immediate_update_enable <= CON2_RST[CON2_IUE_BIT];
            dead_time_control_one   <= DTC_RST;
            dead_time_control_two   <= DTC_RST;
            output_override_control <= OVD_RST;
        end else if (ce) begin
            if (wr_en && sel_tbcon) begin
                // A software write wins over the single-pulse clear
                time_base_enable     <= wd[TBCON_EN_BIT];
                time_base_mode_field <= wd[TBCON_MODE_LSB +: 2];
            end else if (sp_end) begin
                time_base_enable <= 1'b0; // RULE21
            end
            if (wr_en && sel_period) begin
                period_buffer <= wd[CNT_W-1:0];
            end
            if (wr_en && sel_con1) begin
                pair_mode_select <= wd[NPAIR-1:0]; // RULE10
            end
            if (wr_en && sel_con2) begin
                update_disable          <= wd[CON2_UPDATE_DISABLE_BIT];
                immediate_update_enable <= wd[CON2_IUE_BIT];
            end
            if (wr_en && sel_dtc1) begin
                dead_time_control_one <= wd; // RULE15
            end
            if (wr_en && sel_dtc2) begin
                dead_time_control_two <= {10'h000, wd[5:0]}; // RULE13
            end
            if (wr_en && sel_ovd) begin
                output_override_control <= wd; // RULE22
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Period copy and single-pulse events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value      <= PERIOD_RST;
            timer_clear       <= 1'b0;
            single_pulse_done <= 1'b0;
            zero_q            <= 1'b0;
        end else if (ce) begin
            if (per_load) begin
                period_value <= period_buffer;
            end
            timer_clear       <= sp_end; // RULE21
            single_pulse_done <= sp_end; // RULE21
            zero_q            <= count_zero;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Per-pair datapath
    wire [DT_W-1:0]    dt_first  = dead_time_control_one[DTC1_FIRST_LSB +: DT_W];
    wire [DT_W-1:0]    dt_second = dead_time_control_one[DTC1_SECND_LSB +: DT_W];
    wire [DT_PS_W-1:0] ps_first  = dead_time_control_one[DTC1_FPS_LSB +: DT_PS_W];
    wire [DT_PS_W-1:0] ps_second = dead_time_control_one[DTC1_SPS_LSB +: DT_PS_W];

    logic [NPAIR-1:0] next_high;
    logic [NPAIR-1:0] next_low;

    generate
        for (gi = 0; gi < NPAIR; gi++) begin : g_pair
            // Single pulse: the compare dies with the enable, taking the high pins down
            wire cmp_g = cmp_raw[gi] & (~sp_mode | time_base_enable); // RULE20 RULE21

            pdd_duty u_duty (
                .pclk      (pclk),
                .presetn   (presetn),
                .ce        (ce),
                .wr        (wr_en & sel_duty[gi]),
                .wdata     (wd),
                .load      (duty_load),
                .immediate (immediate_update_enable), // RULE7
                .tb_count  (tb_in.count),
                .tb_half   (tb_in.half),
                .buffer    (duty_buffer[gi]),
                .active    (duty_active[gi]),
                .cmp       (cmp_raw[gi])
            );

            pdd_dtu u_dtu (
                .pclk         (pclk),
                .presetn      (presetn),
                .ce           (ce),
                .cmp          (cmp_g), // RULE9
                .independent  (pair_mode_select[gi]), // RULE10 RULE18
                .sel_active   (dead_time_control_two[2*gi]), // RULE13
                .sel_inactive (dead_time_control_two[2*gi+1]), // RULE13
                .dt_first     (dt_first),
                .dt_second    (dt_second),
                .ps_first     (ps_first),
                .ps_second    (ps_second),
                .clear        (dt_clear), // RULE16
                .high         (dt_high[gi]),
                .low          (dt_low[gi])
            );

            // Override bypasses compare and dead time
            assign next_high[gi] = output_override_control[OVD_EN_LSB + 2*gi + 1] ?
                                   output_override_control[2*gi + 1] : dt_high[gi]; // RULE22 RULE19
            assign next_low[gi]  = output_override_control[OVD_EN_LSB + 2*gi] ?
                                   output_override_control[2*gi] : dt_low[gi]; // RULE22 RULE19
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_output <= '0;
            low_side_output  <= '0;
        end else if (ce) begin
            high_side_output <= next_high; // RULE9
            low_side_output  <= next_low; // RULE9
        end
    end

endmodule : pdd_top

// file: tb/pdd_chk.sv
`timescale 1ns/1ps
module pdd_chk #(
    parameter int unsigned NPAIR = 3
) (
    input logic                      pclk,
    input logic                      presetn,
    input logic                      ce,
    input logic                      psel,
    input logic                      penable,
    input logic                      pwrite,
    input logic [pdd_pkg::ADDR_W-1:0] paddr,
    input logic [31:0]               pwdata,
    input logic [31:0]               prdata,
    input logic                      pready,
    input logic                      pslverr,
    input pdd_pkg::pdd_tb_s          tb_in,
    input logic                      time_base_enable,
    input logic [1:0]                time_base_mode_field,
    input logic [pdd_pkg::CNT_W-1:0] period_value,
    input logic                      timer_clear,
    input logic                      single_pulse_done,
    input logic [NPAIR-1:0]          high_side_output,
    input logic [NPAIR-1:0]          low_side_output
);
    import pdd_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    property p_ready_next; psel && !penable && ce |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
    property p_ready_once; pready && ce |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("answer too long");
    property p_err_ready; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without answer");
    property p_rd_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    property p_rd_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
    property p_sp_end; single_pulse_done && !$past(pready && pwrite && paddr == ADDR_TBCON) |->
        timer_clear && !time_base_enable; endproperty
    a_sp_end: assert property (p_sp_end) else $error("pulse end incomplete");
    property p_sp_cause; single_pulse_done |-> $past(tb_in.period_match) && time_base_mode_field == MODE_SINGLE;
    endproperty
    a_sp_cause: assert property (p_sp_cause) else $error("pulse end without match");
    property p_sp_quiet; single_pulse_done |=> !timer_clear [*2]; endproperty
    a_sp_quiet: assert property (p_sp_quiet) else $error("timer clear repeated");
    c_sp: cover property (single_pulse_done);
    c_err: cover property (pslverr);
    c_both: cover property (high_side_output[1] && low_side_output[1]);
endmodule : pdd_chk

bind pdd_top pdd_chk #(.NPAIR(NPAIR)) chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tb_in(tb_in), .time_base_enable(time_base_enable),
    .time_base_mode_field(time_base_mode_field), .period_value(period_value), .timer_clear(timer_clear),
    .single_pulse_done(single_pulse_done), .high_side_output(high_side_output), .low_side_output(low_side_output));

// file: tb/pdd_bridge.sv
`timescale 1ns/1ps
module pdd_bridge #(
    parameter int unsigned NPAIR = 3
) (
    input  logic             pclk,
    input  logic [NPAIR-1:0] arm,
    input  logic [NPAIR-1:0] high,
    input  logic [NPAIR-1:0] low,
    output logic [7:0]       shoot_cnt
);
    // Both switches of an armed leg on means a shorted rail
    initial shoot_cnt = 8'h00;
    always @(posedge pclk) begin
        if (|(arm & high & low)) shoot_cnt <= shoot_cnt + 8'h01;
    end
endmodule : pdd_bridge

// file: tb/pdd_tb_top.sv
`timescale 1ns/1ps
module pdd_tb_top;
    import pdd_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, half_idle = 0, rd_err;
    logic [7:0] paddr = 8'h00, shoot_cnt;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
    logic pready, pslverr, time_base_enable, timer_clear, single_pulse_done;
    logic [1:0] time_base_mode_field;
    logic [CNT_W-1:0] period_value;
    logic [2:0] high_side_output, low_side_output, arm = 3'b000;
    pdd_tb_s tb_in = '0;
    int err_count = 0, cmp_count = 0, cyc = 0;

    always #10 pclk = ~pclk;
    // Stand-in time base: half steps only while enabled
    always @(posedge pclk) begin
        if (!time_base_enable || timer_clear) begin
            tb_in <= '{count: '0, dir: 1'b0, half: half_idle, period_match: 1'b0};
        end else begin
            tb_in.half <= ~tb_in.half;
            tb_in.count <= tb_in.count + 15'(tb_in.half);
            tb_in.period_match <= !tb_in.half && tb_in.count == period_value;
        end
    end
    pdd_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tb_in(tb_in),
        .time_base_enable(time_base_enable), .time_base_mode_field(time_base_mode_field),
        .period_value(period_value), .timer_clear(timer_clear), .single_pulse_done(single_pulse_done),
        .high_side_output(high_side_output), .low_side_output(low_side_output));
    pdd_bridge bridge_u (.pclk(pclk), .arm(arm), .high(high_side_output), .low(low_side_output),
        .shoot_cnt(shoot_cnt));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(rd_data, exp);
    endtask : rd_chk
    // Pins are one flop behind the compare, four cycles is ample
    task pins(input int p, input logic [1:0] exp);
        repeat (4) @(posedge pclk);
        chk({30'h0, high_side_output[p], low_side_output[p]}, {30'h0, exp});
    endtask : pins
    task gap(input int exp_len, input logic hi_end);
        int n;
        n = 0;
        while (!(high_side_output[0] === 1'b0 && low_side_output[0] === 1'b0) && n < 50) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (high_side_output[0] === 1'b0 && low_side_output[0] === 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), 32'(exp_len));
        chk({30'h0, high_side_output[0], low_side_output[0]}, {30'h0, hi_end, ~hi_end});
    endtask : gap
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        int h, n;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CON1, 32'h0000_0000);
        apb(1'b1, ADDR_DUTY_BASE, 16'hA5C3);
        rd_chk(ADDR_DUTY_BASE, 32'h0000_A5C3);
        apb(1'b0, 8'hFC, 16'h0000);
        chk({rd_data[30:0], rd_err}, 32'h0000_0001);
        $display("test registers done");
        apb(1'b1, ADDR_CON1, 16'h0006);
        apb(1'b1, ADDR_DUTY_BASE + ADDR_DUTY_STEP, 16'h0001);
        pins(1, 2'b11);
        half_idle <= 1'b1;
        pins(1, 2'b00);
        half_idle <= 1'b0;
        apb(1'b1, ADDR_OVD, 16'h3020);
        pins(2, 2'b10);
        rd_chk(ADDR_OVD, 32'h0000_3020);
        apb(1'b1, ADDR_OVD, 16'h0000);
        apb(1'b1, ADDR_CON2, 16'h0001);
        apb(1'b1, ADDR_DUTY_BASE + 8'h08, 16'hFFFF);
        pins(2, 2'b00);
        apb(1'b1, ADDR_CON2, 16'h0003);
        apb(1'b1, ADDR_DUTY_BASE + 8'h08, 16'hFFFF);
        pins(2, 2'b11);
        apb(1'b1, ADDR_CON2, 16'h0000);
        $display("test independent and override done");
        // First: 3 ticks of 2, second: 2 ticks of 8
        apb(1'b1, ADDR_DUTY_BASE, 16'h0000);
        apb(1'b1, ADDR_DTC1, 16'hC243);
        apb(1'b1, ADDR_DTC2, 16'h0002);
        pins(0, 2'b01);
        arm <= 3'b001;
        apb(1'b1, ADDR_DUTY_BASE, 16'h0001);
        gap(7, 1'b1);
        apb(1'b1, ADDR_DUTY_BASE, 16'h0000);
        gap(17, 1'b0);
        chk(32'(shoot_cnt), 32'h0000_0000);
        $display("test dead time done");
        apb(1'b1, ADDR_PERIOD, 16'h0004);
        apb(1'b1, ADDR_DUTY_BASE + ADDR_DUTY_STEP, 16'h0004);
        apb(1'b1, ADDR_TBCON, 16'h0002);
        pins(1, 2'b00);
        apb(1'b1, ADDR_TBCON, 16'h8002);
        h = 0;
        n = 0;
        while (single_pulse_done !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
            if (high_side_output[1] === 1'b1) h++;
        end
        chk(32'(h), 32'h0000_0004);
        rd_chk(ADDR_TBCON, 32'h0000_0002);
        pins(1, 2'b00);
        chk(32'(period_value), 32'h0000_0004);
        $display("test single pulse done");
        tally_and_finish();
    end
endmodule : pdd_tb_top
